// *** slm_pkg.sv ***
package slm_pkg;

  // ****************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_COUNT   = 5'h04;
  localparam logic [4:0] ADDR_FILTER  = 5'h08;
  localparam logic [4:0] ADDR_GRT     = 5'h0C;
  localparam logic [4:0] ADDR_RES_LO  = 5'h10;
  localparam logic [4:0] ADDR_RES_HI  = 5'h14;
  localparam logic [4:0] ADDR_STATUS  = 5'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_ENABLE  = 0;
  localparam int CTL_SINGLE  = 1;
  localparam int CTL_CHAN_LO = 2;
  localparam int CNT_K_LO    = 11;
  localparam int FLT_ENABLE  = 0;
  localparam int FLT_SHAPE   = 1;
  localparam int FLT_BP_SRC  = 2;
  localparam int FLT_NT_SRC  = 3;
  localparam int FLT_OFS_SRC = 4;
  localparam int GRT_GAIN    = 0;
  localparam int GRT_RECT    = 1;
  localparam int GRT_THR_LO  = 2;
  localparam int GRT_OVER    = 5;
  localparam int STA_DONE    = 0;

  // ****************************************************************
  // widths, reset values, fixed coefficients
  // ****************************************************************
  localparam int COUNT_W  = 11;
  localparam int SAMPLE_W = 16;
  localparam int ACC_W    = 27;
  localparam int NUM_CH   = 4;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 11'h7FF;
  localparam logic [3:0]  SHIFT_MAX     = 4'hB;
  localparam logic        COEF_SRC_ROM  = 1'b1;
  localparam logic [15:0] ROM_BP_COEF   = 16'h7000;
  localparam logic [15:0] ROM_NT_COEF   = 16'h7000;
  localparam int          COEF_FRAC     = 14;
  localparam int          GAIN_SHIFT    = 4;
  localparam int          THR_STEP_LOG2 = 12;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // ****************************************************************
  // timing: done flag self-clear in continuous mode
  // ****************************************************************
  localparam int CLK_HZ          = 40_000_000;
  localparam int DONE_CLEAR_NS   = 125_000;
  localparam int DONE_CLEAR_CYC  =
    (CLK_HZ / 1_000_000) * DONE_CLEAR_NS / 1_000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } slm_state_t;

endpackage : slm_pkg

// *** slm_cfg_if.sv ***
interface slm_cfg_if;
  logic        sample_strobe;
  logic [63:0] channel_samples;
  logic [1:0]  meter_channel_select;
  logic        meter_filter_enable;
  logic        filter_shape_select;
  logic        bandpass_coef_source;
  logic        notch_coef_source;
  logic        offset_source_select;
  logic        extra_gain_select;
  logic        rectifier_enable;
  logic [15:0] ram_bp_coef;
  logic [15:0] ram_notch_coef;
  logic [15:0] ram_dc_offset;
  logic        clear_state;
  logic [15:0] proc_sample;
  logic        proc_valid;

  modport ctrl (
    output sample_strobe, channel_samples, meter_channel_select,
           meter_filter_enable, filter_shape_select,
           bandpass_coef_source, notch_coef_source,
           offset_source_select, extra_gain_select, rectifier_enable,
           ram_bp_coef, ram_notch_coef, ram_dc_offset, clear_state,
    input  proc_sample, proc_valid
  );
  modport prep (
    input  sample_strobe, channel_samples, meter_channel_select,
           meter_filter_enable, filter_shape_select,
           bandpass_coef_source, notch_coef_source,
           offset_source_select, extra_gain_select, rectifier_enable,
           ram_bp_coef, ram_notch_coef, ram_dc_offset, clear_state,
    output proc_sample, proc_valid
  );
endinterface : slm_cfg_if

// *** slm_prep.sv ***
module slm_prep (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  slm_cfg_if.prep   cfg
);

  // ****************************************************************
  // sample path: channel, offset, filter, gain, rectifier
  // ****************************************************************
  logic signed [19:0] x1;
  logic signed [19:0] x2;
  logic signed [19:0] y1;
  logic signed [19:0] y2;
  logic signed [19:0] x_in;
  logic signed [19:0] bp_out;
  logic signed [19:0] flt_out;
  logic signed [23:0] gained;
  logic signed [15:0] sat;
  logic signed [15:0] coef;
  logic signed [35:0] prod;
  logic signed [15:0] sel_sample;
  logic signed [15:0] offset;

  // channel and offset selection
  always_comb begin
    sel_sample = cfg.channel_samples[cfg.meter_channel_select*16 +: 16];
    offset = cfg.offset_source_select ? 16'sh0000
                                      : $signed(cfg.ram_dc_offset); // [RL15]
    x_in = 20'(sel_sample) - 20'(offset); // [RL3]
  end

  // resonator: notch is input minus the bandpass response
  always_comb begin
    if (cfg.filter_shape_select) begin // [RL7]
      coef = (cfg.bandpass_coef_source == slm_pkg::COEF_SRC_ROM) ?
             $signed(slm_pkg::ROM_BP_COEF) : $signed(cfg.ram_bp_coef); // [RL8]
    end else begin
      coef = (cfg.notch_coef_source == slm_pkg::COEF_SRC_ROM) ?
             $signed(slm_pkg::ROM_NT_COEF) : $signed(cfg.ram_notch_coef); // [RL9]
    end
    prod   = 36'(coef) * 36'(y1);
    bp_out = ((x_in - x2) >>> 3) + 20'(prod >>> slm_pkg::COEF_FRAC)
             - y2 + (y2 >>> 4);
    if (!cfg.meter_filter_enable) begin
      flt_out = x_in; // [RL6]
    end else if (cfg.filter_shape_select) begin
      flt_out = bp_out;
    end else begin
      flt_out = x_in - bp_out;
    end
  end

  // gain of 16 ahead of rectifier; saturate so |x| fits 16 bits
  always_comb begin
    gained = cfg.extra_gain_select ?
             (24'(flt_out) <<< slm_pkg::GAIN_SHIFT) : 24'(flt_out); // [RL12]
    if (gained > 24'sd32767) begin
      sat = 16'sh7FFF;
    end else if (gained < -24'sd32767) begin
      sat = -16'sh7FFF; // symmetric so the rectifier never overflows
    end else begin
      sat = gained[15:0];
    end
  end

  // filter history, cleared whenever metering stops
  always_ff @(posedge i_mclk) begin
    if (i_reset || cfg.clear_state) begin
      x1 <= '0;
      x2 <= '0;
      y1 <= '0;
      y2 <= '0;
    end else if (cfg.sample_strobe) begin
      x1 <= x_in;
      x2 <= x1;
      y1 <= bp_out;
      y2 <= y1;
    end
  end

  // registered output sample, one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cfg.proc_sample <= '0;
      cfg.proc_valid  <= 1'b0;
    end else begin
      cfg.proc_valid <= cfg.sample_strobe && !cfg.clear_state;
      if (cfg.sample_strobe) begin
        cfg.proc_sample <= (cfg.rectifier_enable && sat < 0) ?
                           -sat : sat; // [RL13]
      end
    end
  end

endmodule : slm_prep

// *** slm_meter.sv ***
// Behaviour
// RL1: after each latch, set over-threshold flag when result magnitude exceeds threshold
// RL2: threshold code steps full scale in eighths, 000 is 0%, 111 is 87.5%
// RL3: two-bit channel select picks the measured codec channel
// RL4: eleven-bit count up to 7FF, one 0.125 ms sample per unit
// RL5: result readable as low byte and high byte registers
// RL6: filter enable off passes signal straight, on filters before gain
// RL7: shape select 0 gives notch, 1 gives bandpass
// RL8: bandpass coefficient from RAM at 0, ROM at 1, ROM after reset
// RL9: notch coefficient from RAM at 0, ROM at 1, ROM after reset
// RL10: enable high starts a measurement, enable low stops it
// RL11: done flag set when an integration period completes
// RL12: extra gain select multiplies by 1 or 16 before rectifier
// RL13: rectifier enable turns negative samples positive before integrating
// RL14: single-shot bit chooses one integration or continuous repetition
// RL15: offset taken from RAM offset word at 0, zero at 1
// RL16: continuous runs back to back, pulse each completion, done clears after 125 us
// RL17: single-shot integrates once, done held until enable cleared
// RL18: result is 16-bit two's complement, 8000 to 7FFF
// RL19: result bytes held cleared while the meter is disabled
// RL20: strict greater-than against code times 4096, updated only at latch
module slm_meter #(
  parameter int DONE_CLEAR_CYCLES = slm_pkg::DONE_CLEAR_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_sample_strobe,
  input  wire logic [63:0] i_channel_samples,
  input  wire logic [15:0] i_ram_bp_coef,
  input  wire logic [15:0] i_ram_notch_coef,
  input  wire logic [15:0] i_ram_dc_offset,
  output logic             o_measure_done_flag,
  output logic             o_over_threshold_flag,
  output logic             o_done_pulse
);

  // ****************************************************************
  // software-visible state
  // ****************************************************************
  logic                       meter_enable;
  logic                       single_shot_mode;
  logic [1:0]                 meter_channel_select;
  logic [slm_pkg::COUNT_W-1:0] integration_count;
  logic [3:0]                 shift_select;
  logic                       meter_filter_enable;
  logic                       filter_shape_select;
  logic                       bandpass_coef_source;
  logic                       notch_coef_source;
  logic                       offset_source_select;
  logic                       extra_gain_select;
  logic                       rectifier_enable;
  logic [2:0]                 threshold_select;
  logic [7:0]                 result_low_byte;
  logic [7:0]                 result_high_byte;
  logic                       over_threshold_flag;
  logic                       measure_done_flag;

  // ****************************************************************
  // integrator state
  // ****************************************************************
  slm_pkg::slm_state_t        state;
  slm_pkg::slm_state_t        next_state;
  logic signed [slm_pkg::ACC_W-1:0] acc;
  logic [slm_pkg::COUNT_W-1:0] sample_cnt;
  logic [15:0]                done_timer;
  logic                       period_end;
  logic signed [slm_pkg::ACC_W-1:0] acc_sum;
  logic signed [slm_pkg::ACC_W-1:0] shifted;
  logic signed [15:0]         result_sat;
  logic [16:0]                result_mag;
  logic [16:0]                threshold_lvl;
  logic                       bus_req;
  logic                       bus_wr;

  slm_cfg_if cfg ();

  // ****************************************************************
  // sample pre-processing stage
  // ****************************************************************
  assign cfg.sample_strobe        = i_sample_strobe;
  assign cfg.channel_samples      = i_channel_samples;
  assign cfg.meter_channel_select = meter_channel_select;
  assign cfg.meter_filter_enable  = meter_filter_enable;
  assign cfg.filter_shape_select  = filter_shape_select;
  assign cfg.bandpass_coef_source = bandpass_coef_source;
  assign cfg.notch_coef_source    = notch_coef_source;
  assign cfg.offset_source_select = offset_source_select;
  assign cfg.extra_gain_select    = extra_gain_select;
  assign cfg.rectifier_enable     = rectifier_enable;
  assign cfg.ram_bp_coef          = i_ram_bp_coef;
  assign cfg.ram_notch_coef       = i_ram_notch_coef;
  assign cfg.ram_dc_offset        = i_ram_dc_offset;
  assign cfg.clear_state          = !meter_enable;

  slm_prep slm_prep_inst (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .cfg     (cfg.prep)
  );

  // ****************************************************************
  // avalon-mm slave: one wait cycle, then a single ready cycle
  // ****************************************************************
  assign bus_req = i_avs_read || i_avs_write;
  assign bus_wr  = i_avs_write && !o_avs_waitrequest;

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
    end
  end

  // read data registered while waitrequest is still high
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && o_avs_waitrequest) begin
      case (i_avs_address)
        slm_pkg::ADDR_CONTROL: begin
          o_avs_readdata <= {28'h000_0000, meter_channel_select,
                             single_shot_mode, meter_enable};
        end
        slm_pkg::ADDR_COUNT: begin
          o_avs_readdata <= {17'h0_0000, shift_select, integration_count};
        end
        slm_pkg::ADDR_FILTER: begin
          o_avs_readdata <= {27'h000_0000, offset_source_select,
                             notch_coef_source, bandpass_coef_source,
                             filter_shape_select, meter_filter_enable};
        end
        slm_pkg::ADDR_GRT: begin
          o_avs_readdata <= {26'h000_0000, over_threshold_flag,
                             threshold_select, rectifier_enable,
                             extra_gain_select};
        end
        slm_pkg::ADDR_RES_LO: begin
          o_avs_readdata <= {24'h00_0000, result_low_byte}; // [RL5]
        end
        slm_pkg::ADDR_RES_HI: begin
          o_avs_readdata <= {24'h00_0000, result_high_byte}; // [RL5]
        end
        slm_pkg::ADDR_STATUS: begin
          o_avs_readdata <= {31'h0000_0000, measure_done_flag};
        end
        default: begin
          o_avs_readdata <= slm_pkg::READ_UNMAPPED;
        end
      endcase
    end
  end

  // control word: enable, mode, channel
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      meter_enable         <= 1'b0;
      single_shot_mode     <= 1'b0;
      meter_channel_select <= 2'b00;
    end else if (bus_wr && i_avs_address == slm_pkg::ADDR_CONTROL) begin
      meter_enable         <= i_avs_writedata[slm_pkg::CTL_ENABLE]; // [RL10]
      single_shot_mode     <= i_avs_writedata[slm_pkg::CTL_SINGLE]; // [RL14]
      meter_channel_select <= i_avs_writedata[slm_pkg::CTL_CHAN_LO +: 2];
    end
  end

  // count and shift factor; shift codes above eleven act as eleven
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      integration_count <= slm_pkg::COUNT_RESET;
      shift_select      <= 4'h0;
    end else if (bus_wr && i_avs_address == slm_pkg::ADDR_COUNT) begin
      integration_count <= i_avs_writedata[slm_pkg::COUNT_W-1:0]; // [RL4]
      shift_select      <= i_avs_writedata[slm_pkg::CNT_K_LO +: 4];
    end
  end

  // filter configuration; rom coefficients after reset
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      meter_filter_enable  <= 1'b0;
      filter_shape_select  <= 1'b0;
      bandpass_coef_source <= slm_pkg::COEF_SRC_ROM; // [RL8]
      notch_coef_source    <= slm_pkg::COEF_SRC_ROM; // [RL9]
      offset_source_select <= 1'b0;
    end else if (bus_wr && i_avs_address == slm_pkg::ADDR_FILTER) begin
      meter_filter_enable  <= i_avs_writedata[slm_pkg::FLT_ENABLE];
      filter_shape_select  <= i_avs_writedata[slm_pkg::FLT_SHAPE];
      bandpass_coef_source <= i_avs_writedata[slm_pkg::FLT_BP_SRC];
      notch_coef_source    <= i_avs_writedata[slm_pkg::FLT_NT_SRC];
      offset_source_select <= i_avs_writedata[slm_pkg::FLT_OFS_SRC];
    end
  end

  // gain, rectifier, threshold code
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      extra_gain_select <= 1'b0;
      rectifier_enable  <= 1'b0;
      threshold_select  <= 3'b000;
    end else if (bus_wr && i_avs_address == slm_pkg::ADDR_GRT) begin
      extra_gain_select <= i_avs_writedata[slm_pkg::GRT_GAIN];
      rectifier_enable  <= i_avs_writedata[slm_pkg::GRT_RECT];
      threshold_select  <= i_avs_writedata[slm_pkg::GRT_THR_LO +: 3];
    end
  end

  // ****************************************************************
  // integrator and sequencing
  // ****************************************************************
  // count of n means n+1 samples, so the period ends on sample_cnt == n
  assign period_end = cfg.proc_valid && (sample_cnt == integration_count);
  assign acc_sum    = acc + slm_pkg::ACC_W'($signed(cfg.proc_sample));

  // scale by shift factor and clamp into the 16-bit result range
  always_comb begin
    shifted = acc_sum >>> ((shift_select > slm_pkg::SHIFT_MAX) ?
                           slm_pkg::SHIFT_MAX : shift_select);
    if (shifted > slm_pkg::ACC_W'(32767)) begin
      result_sat = 16'sh7FFF; // [RL18]
    end else if (shifted < -slm_pkg::ACC_W'(32768)) begin
      result_sat = 16'sh8000; // [RL18]
    end else begin
      result_sat = shifted[15:0];
    end
    result_mag    = result_sat[15] ? 17'(-$signed({result_sat[15], result_sat}))
                                   : {1'b0, result_sat};
    threshold_lvl = 17'(threshold_select) << slm_pkg::THR_STEP_LOG2; // [RL2]
  end

  // state transitions
  always_comb begin
    next_state = state;
    case (state)
      slm_pkg::ST_IDLE: begin
        if (meter_enable) begin
          next_state = slm_pkg::ST_RUN; // [RL10]
        end
      end
      slm_pkg::ST_RUN: begin
        if (!meter_enable) begin
          next_state = slm_pkg::ST_IDLE; // [RL10]
        end else if (period_end && single_shot_mode) begin
          next_state = slm_pkg::ST_HOLD; // [RL17]
        end
      end
      slm_pkg::ST_HOLD: begin
        // a fresh run needs enable to fall first
        if (!meter_enable) begin
          next_state = slm_pkg::ST_IDLE; // [RL17]
        end
      end
      default: begin
        next_state = slm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= slm_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // accumulator restarts straight after a period in continuous mode
  always_ff @(posedge i_mclk) begin
    if (i_reset || state != slm_pkg::ST_RUN) begin
      acc        <= '0;
      sample_cnt <= '0;
    end else if (period_end) begin
      acc        <= '0; // [RL16]
      sample_cnt <= '0;
    end else if (cfg.proc_valid) begin
      acc        <= acc_sum;
      sample_cnt <= sample_cnt + 1'b1;
    end
  end

  // result latch; cleared while disabled
  always_ff @(posedge i_mclk) begin
    if (i_reset || !meter_enable) begin
      result_low_byte  <= 8'h00; // [RL19]
      result_high_byte <= 8'h00; // [RL19]
    end else if (state == slm_pkg::ST_RUN && period_end) begin
      result_low_byte  <= result_sat[7:0]; // [RL5]
      result_high_byte <= result_sat[15:8]; // [RL5]
    end
  end

  // over-threshold: re-evaluated only when a result is latched
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      over_threshold_flag <= 1'b0;
    end else if (meter_enable && state == slm_pkg::ST_RUN && period_end) begin
      over_threshold_flag <= (result_mag > threshold_lvl); // [RL1] [RL20]
    end
  end

  // done flag: held in single-shot, timed clear in continuous mode
  always_ff @(posedge i_mclk) begin
    if (i_reset || !meter_enable) begin
      measure_done_flag <= 1'b0; // [RL17]
      done_timer        <= '0;
    end else if (state == slm_pkg::ST_RUN && period_end) begin
      measure_done_flag <= 1'b1; // [RL11]
      done_timer        <= 16'(DONE_CLEAR_CYCLES - 1);
    end else if (measure_done_flag && !single_shot_mode) begin
      if (done_timer == 16'h0000) begin
        measure_done_flag <= 1'b0; // [RL16]
      end else begin
        done_timer <= done_timer - 1'b1;
      end
    end
  end

  // ****************************************************************
  // registered status outputs
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_measure_done_flag   <= 1'b0;
      o_over_threshold_flag <= 1'b0;
      o_done_pulse          <= 1'b0;
    end else begin
      o_measure_done_flag   <= measure_done_flag;
      o_over_threshold_flag <= over_threshold_flag;
      o_done_pulse <= meter_enable && state == slm_pkg::ST_RUN
                      && period_end; // [RL16]
    end
  end

endmodule : slm_meter

// *** slm_meter_properties.sv ***
// ****
// bus and flag relations seen at the meter ports
// ****
module slm_meter_properties (
  input wire logic        i_mclk,
  input wire logic        i_reset,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_measure_done_flag,
  input wire logic        o_over_threshold_flag,
  input wire logic        o_done_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // read answered at this edge
  wire logic ans_rd = i_avs_read && !o_avs_waitrequest;
  sequence s_req; $rose(i_avs_read || i_avs_write); endsequence
  sequence s_ans; !o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
  a_req_answer: assert property (s_req |=> s_ans)
    else $error("bus answer late or too long");
  a_idle_wait: assert property (!(i_avs_read || i_avs_write)
    |-> o_avs_waitrequest) else $error("waitrequest low while idle");
  a_unmapped_zero: assert property ((ans_rd && i_avs_address == 5'h1C)
    |-> o_avs_readdata == 32'h0000_0000) else $error("unmapped read");
  a_pulse_single: assert property (o_done_pulse |=> !o_done_pulse)
    else $error("done pulse longer than one cycle");
  a_pulse_done: assert property (o_done_pulse |-> ##[0:1] o_measure_done_flag)
    else $error("done pulse without done flag");
  a_over_latch: assert property ($changed(o_over_threshold_flag)
    |-> o_done_pulse || $past(o_done_pulse)) else $error("over flag moved");
  a_over_readback: assert property ((ans_rd && !o_done_pulse
    && i_avs_address == slm_pkg::ADDR_GRT && $stable(o_over_threshold_flag))
    |-> o_avs_readdata[5] == o_over_threshold_flag) else $error("over bit");
  a_done_readback: assert property ((ans_rd && !o_done_pulse
    && i_avs_address == slm_pkg::ADDR_STATUS && $stable(o_measure_done_flag))
    |-> o_avs_readdata[0] == o_measure_done_flag) else $error("done bit");
endmodule : slm_meter_properties

// *** slm_meter_bench.sv ***
module slm_meter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, rd, wr, stb, busy, done, over, pulse;
  logic [4:0]  adr;
  logic [31:0] wd, rdata, q, cnt;
  logic [63:0] smp;
  logic [15:0] ofs;
  int          miscompares, num_checks, cyc, npls;
  // short done-clear count keeps the continuous run brief
  slm_meter #(.DONE_CLEAR_CYCLES(20)) slm_meter_inst (.i_mclk(clk),
    .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(busy),
    .i_sample_strobe(stb), .i_channel_samples(smp),
    .i_ram_bp_coef(16'h1000), .i_ram_notch_coef(16'h1000),
    .i_ram_dc_offset(ofs), .o_measure_done_flag(done),
    .o_over_threshold_flag(over), .o_done_pulse(pulse));
  // ****
  // clock and hang guard
  // ****
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // whole run is about 1500 cycles; far beyond means a hang
  always @(posedge clk) begin
    cyc++;
    if (pulse === 1'b1) npls++; // completion pulses seen so far
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // request held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a; wd <= d; wr <= w; rd <= !w;
    do @(posedge clk); while (busy !== 1'b0);
    q = rdata;
    wr <= 1'b0; rd <= 1'b0;
  endtask : bus
  task feed(input int n);
    repeat (n) begin
      @(posedge clk) stb <= 1'b1;
      @(posedge clk) stb <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : feed
  // fresh start every time, four samples per period
  task meas(input logic [63:0] v, input logic [31:0] f, g, c);
    smp <= v;
    bus(1'b1, slm_pkg::ADDR_CONTROL, 32'h0000_0000);
    bus(1'b1, slm_pkg::ADDR_FILTER, f);
    bus(1'b1, slm_pkg::ADDR_GRT, g);
    bus(1'b1, slm_pkg::ADDR_COUNT, cnt);
    bus(1'b1, slm_pkg::ADDR_CONTROL, c);
    feed(4);
    repeat (8) @(posedge clk);
  endtask : meas
  task res(input logic [15:0] e);
    bus(1'b0, slm_pkg::ADDR_RES_LO, 32'h0000_0000);
    chk("result low", {24'h00_0000, e[7:0]}, q);
    bus(1'b0, slm_pkg::ADDR_RES_HI, 32'h0000_0000);
    chk("result high", {24'h00_0000, e[15:8]}, q);
  endtask : res
  task t_reset;
    bus(1'b0, slm_pkg::ADDR_FILTER, 32'h0000_0000);
    chk("coef sources", 32'h0000_0003, {30'h0, q[3:2]});
    bus(1'b0, slm_pkg::ADDR_COUNT, 32'h0000_0000);
    chk("count", 32'h0000_07FF, {21'h0, q[10:0]});
    bus(1'b0, 5'h1C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    $display("reset values done");
  endtask : t_reset
  task t_single;
    ofs <= 16'h0010;
    meas({4{16'h0110}}, 32'h0000_0000, 32'h0000_0000, 32'h0000_000B);
    res(16'h0400);
    repeat (30) @(posedge clk);
    chk("done held", 32'h1, {31'h0, done});
    bus(1'b0, slm_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status done", 32'h0000_0001, q);
    bus(1'b1, slm_pkg::ADDR_CONTROL, 32'h0000_0000);
    res(16'h0000);
    chk("done cleared", 32'h0, {31'h0, done});
    $display("single shot done");
  endtask : t_single
  task t_chan;
    for (int c = 0; c < 4; c++) begin
      meas({16'h0040, 16'h0030, 16'h0020, 16'h0010}, 32'h0000_0010,
           32'h0000_0000, 32'(3 + 4 * c));
      res(16'(64 * (c + 1)));
    end
    $display("channels done");
  endtask : t_chan
  task t_gain;
    for (int g = 0; g < 4; g++) begin
      meas({4{16'hFFF0}}, 32'h0000_0010, 32'(g), 32'h0000_000B);
      res(16'((g[1] ? 64 : -64) * (g[0] ? 16 : 1)));
    end
    $display("gain and rectifier done");
  endtask : t_gain
  task t_thresh;
    for (int c = 0; c < 8; c++) begin
      for (int b = 0; b < 2; b++) begin
        meas({4{16'(c * 1024 + b)}}, 32'h0000_0010, 32'(c * 4), 32'hB);
        chk("over flag", 32'(b), {31'h0, over});
      end
    end
    bus(1'b0, slm_pkg::ADDR_GRT, 32'h0000_0000);
    chk("gain rect thr", 32'h0000_003C, q);
    $display("thresholds done");
  endtask : t_thresh
  task t_cont;
    int p0;
    p0 = npls;
    meas({4{16'h0100}}, 32'h0000_0010, 32'h0000_0000, 32'h0000_0009);
    chk("done set", 32'h1, {31'h0, done});
    repeat (20) @(posedge clk);
    chk("done self clear", 32'h0, {31'h0, done});
    feed(4);
    repeat (8) @(posedge clk);
    chk("next period", 32'h1, {31'h0, done});
    chk("done pulses", 32'h0000_0002, 32'(npls - p0));
    $display("continuous done");
  endtask : t_cont
  // clamp at both ends, then shift codes 3 and 15 (acts as 11)
  task t_shift;
    meas({4{16'h7FFF}}, 32'h0000_0010, 32'h0000_0000, 32'h0000_000B);
    res(16'h7FFF);
    meas({4{16'h8001}}, 32'h0000_0010, 32'h0000_0000, 32'h0000_000B);
    res(16'h8000);
    cnt = 32'h0000_1803;
    meas({4{16'h7FFF}}, 32'h0000_0010, 32'h0000_0000, 32'h0000_000B);
    res(16'h3FFF);
    cnt = 32'h0000_7803;
    meas({4{16'h7FFF}}, 32'h0000_0010, 32'h0000_0000, 32'h0000_000B);
    res(16'h003F);
    cnt = 32'h0000_0003;
    $display("shift and saturation done");
  endtask : t_shift
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    rst = 1'b1; rd = 1'b0; wr = 1'b0; stb = 1'b0; adr = 5'h00;
    wd = 32'h0000_0000; smp = 64'h0; ofs = 16'h0000;
    miscompares = 0; num_checks = 0; cyc = 0;
    npls = 0;
    cnt = 32'h0000_0003;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset(); t_single(); t_chan(); t_gain();
    t_thresh(); t_cont(); t_shift();
    complete_run();
  end
endmodule : slm_meter_bench
bind slm_meter slm_meter_properties slm_meter_properties_inst (.i_mclk,
  .i_reset, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .o_measure_done_flag, .o_over_threshold_flag,
  .o_done_pulse);
